/* core/hps_cfg.svh */
// Constants for the host protocol selector.
// Assumes inclusion by the design module only.
`ifndef HPS_CFG_SVH
`define HPS_CFG_SVH
`define HPS_MB_MAX_SEL 8'h07
`define HPS_CHAR_CR 8'h0d
`define HPS_CHAR_LF 8'h0a
`define HPS_CHAR_EQ 8'h3d
`define HPS_CHAR_BANG 8'h21
`define HPS_CHAR_SP 8'h20
`define HPS_CLK_MHZ 100
`define HPS_MB_GAP_US 40
`define HPS_MB_GAP_CYC ((`HPS_MB_GAP_US * `HPS_CLK_MHZ) > 0 ? (`HPS_MB_GAP_US * `HPS_CLK_MHZ) : 1)
`define HPS_LINE_MAX 64
`endif

/* core/hps_pkg.sv */
// Types for the host protocol selector.
// Assumes the cfg header is compiled alongside.
package hps_pkg;
  typedef enum logic [1:0] {
    HPS_WAIT = 2'b00,
    HPS_MODBUS = 2'b01,
    HPS_TEXT = 2'b10
  } hps_mode_t;
  typedef enum logic [1:0] {
    HPS_CMD_QUERY = 2'b00,
    HPS_CMD_SET = 2'b01,
    HPS_CMD_COIL = 2'b10,
    HPS_CMD_NONE = 2'b11
  } hps_cmd_t;
endpackage

/* core/hps_selector.sv */
// Host protocol selector: watches the host byte stream, locks a protocol.
// Assumes a byte link delivering one-cycle strobes in the i_mclk domain.
// Assumes the Modbus and text consumers take one-cycle pulses.
`timescale 1ns/100ps
`include "hps_cfg.svh"
module hps_selector #(
  parameter int GAP_CYC = `HPS_MB_GAP_CYC
) (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  output logic [1:0] o_mode,
  output logic o_mb_valid,
  output logic [7:0] o_mb_data,
  output logic o_mb_sop,
  output logic o_mb_eop,
  output logic o_txt_valid,
  output logic [7:0] o_txt_data,
  output logic o_txt_eol,
  output logic [1:0] o_txt_cmd,
  output logic o_tx_echo
);
  import hps_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  // All state of the selector in one register
  typedef struct packed {
    hps_mode_t mode;
    logic in_pkt;
    logic [31:0] gap;
    logic mb_valid;
    logic [7:0] mb_data;
    logic mb_sop;
    logic mb_eop;
    logic txt_valid;
    logic [7:0] txt_data;
    logic txt_eol;
    logic line_start;
    logic [1:0] tok;
    hps_cmd_t cmd;
    logic tx_echo;
  } hps_state_t;

  // Current and next state
  hps_state_t s_reg;
  hps_state_t s_next;

  // Last idle count before a Modbus packet closes
  localparam logic [31:0] GAP_LAST = 32'(GAP_CYC - 1);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  // Fold upper case letters to lower case
  function automatic logic [7:0] hps_lower(input logic [7:0] c);
    if (c >= 8'h41 && c <= 8'h5a) begin
      return c | 8'h20;
    end
    return c;
  endfunction

  // A set keyword whose letters are still being matched
  function automatic logic hps_set_open(input hps_cmd_t cmd, input logic [1:0] tok);
    return cmd == HPS_CMD_SET && tok != 2'h3;
  endfunction

  // Byte values 0..7 pick the Modbus protocol
  function automatic logic hps_is_mb_sel(input logic [7:0] b);
    return b <= `HPS_MB_MAX_SEL;
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    logic [7:0] c;
    c = hps_lower(i_rx_data);
    s_next = s_reg;
    // Output pulses last a single cycle
    s_next.mb_valid = 1'b0;
    s_next.mb_sop = 1'b0;
    s_next.mb_eop = 1'b0;
    s_next.txt_valid = 1'b0;
    s_next.txt_eol = 1'b0;
    // Nothing received is ever sent back
    s_next.tx_echo = 1'b0;
    // Inter-byte silence closes a Modbus packet
    if (s_reg.mode == HPS_MODBUS && s_reg.in_pkt && !i_rx_valid) begin
      if (s_reg.gap >= GAP_LAST) begin
        s_next.mb_eop = 1'b1;
        s_next.in_pkt = 1'b0;
        s_next.gap = '0;
      end else begin
        s_next.gap = s_reg.gap + 32'h0000_0001;
      end
    end
    // One received byte per strobe
    if (i_rx_valid) begin
      unique case (s_reg.mode)
        HPS_WAIT: begin
          // First byte decides; the byte is also passed on
          if (hps_is_mb_sel(i_rx_data)) begin
            s_next.mode = HPS_MODBUS;
            s_next.mb_valid = 1'b1;
            s_next.mb_data = i_rx_data;
            s_next.mb_sop = 1'b1;
            s_next.in_pkt = 1'b1;
            s_next.gap = '0;
          end else begin
            // Any other value opens a text line
            s_next.mode = HPS_TEXT;
          end
        end
        HPS_MODBUS: begin
          // Locked; byte values no longer affect mode
          s_next.mb_valid = 1'b1;
          s_next.mb_data = i_rx_data;
          s_next.mb_sop = !s_reg.in_pkt;
          s_next.in_pkt = 1'b1;
          s_next.gap = '0;
        end
        HPS_TEXT: begin
          // Locked; every byte except the carriage return is a command character
          s_next.mode = HPS_TEXT;
        end
        default: begin
          // Unused code; settle on the text protocol
          s_next.mode = HPS_TEXT;
        end
      endcase
      // Text path: fold, terminate, classify
      if (s_reg.mode == HPS_TEXT ||
          (s_reg.mode == HPS_WAIT && !hps_is_mb_sel(i_rx_data))) begin
        s_next.txt_data = c;
        if (i_rx_data == `HPS_CHAR_CR) begin
          // Command executes only on the terminator
          s_next.txt_eol = 1'b1;
          s_next.line_start = 1'b1;
          s_next.tok = '0;
          // An empty line or a half-typed set keyword is dropped
          if (s_reg.line_start || hps_set_open(s_reg.cmd, s_reg.tok)) begin
            s_next.cmd = HPS_CMD_NONE;
          end else begin
            s_next.cmd = s_reg.cmd;
          end
        end else begin
          // Ordinary character: forward and classify
          s_next.txt_valid = 1'b1;
          s_next.line_start = 1'b0;
          if (s_reg.line_start) begin
            // Leading token classification
            if (c == `HPS_CHAR_EQ) begin
              s_next.cmd = HPS_CMD_QUERY;
            end else if (c == `HPS_CHAR_BANG) begin
              s_next.cmd = HPS_CMD_COIL;
            end else if (c == 8'h73) begin
              s_next.cmd = HPS_CMD_SET;
              s_next.tok = 2'h1;
            end else begin
              s_next.cmd = HPS_CMD_NONE;
            end
          end else if (hps_set_open(s_reg.cmd, s_reg.tok)) begin
            // Match the remaining letters of the set keyword
            if (s_reg.tok == 2'h1 && c == 8'h65) begin
              s_next.tok = 2'h2;
            end else if (s_reg.tok == 2'h2 && c == 8'h74) begin
              s_next.tok = 2'h3;
            end else begin
              s_next.cmd = HPS_CMD_NONE;
            end
          end
        end
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  // Asynchronous reset; state moves on every rising edge of i_mclk
  always_ff @(posedge i_mclk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      s_reg <= '{mode: HPS_WAIT, line_start: 1'b1, cmd: HPS_CMD_NONE, default: '0};
    end else begin
      s_reg <= s_next;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  // Every output comes straight from a flip-flop
  assign o_mode = s_reg.mode;
  assign o_mb_valid = s_reg.mb_valid;
  assign o_mb_data = s_reg.mb_data;
  assign o_mb_sop = s_reg.mb_sop;
  assign o_mb_eop = s_reg.mb_eop;
  assign o_txt_valid = s_reg.txt_valid;
  assign o_txt_data = s_reg.txt_data;
  assign o_txt_eol = s_reg.txt_eol;
  assign o_txt_cmd = s_reg.cmd;
  assign o_tx_echo = s_reg.tx_echo;
  // Sensor and display logic is outside and never gated here
endmodule // hps_selector

/* verif/hps_host.sv */
// Host side model: sends bytes on a one-cycle strobe.
// Assumes the caller runs in the i_mclk domain.
`timescale 1ns/100ps
module hps_host (
  input wire logic i_mclk,
  output logic o_valid,
  output logic [7:0] o_data
);
  initial begin
    o_valid = 1'b0;
    o_data = 8'h00;
  end
  // One byte, then a released line shows the inverse
  task automatic send(input logic [7:0] b);
    @(negedge i_mclk);
    o_valid = 1'b1;
    o_data = b;
    @(negedge i_mclk);
    o_valid = 1'b0;
    o_data = ~b;
  endtask
endmodule // hps_host

/* verif/hps_chk.sv */
// Port checker for the selector.
// Assumes a bind onto hps_selector.
`timescale 1ns/100ps
module hps_chk (
  input wire logic i_mclk,
  input wire logic i_rst_n,
  input wire logic i_rx_valid,
  input wire logic [7:0] i_rx_data,
  input wire logic [1:0] o_mode,
  input wire logic o_mb_valid,
  input wire logic [7:0] o_mb_data,
  input wire logic o_mb_sop,
  input wire logic o_mb_eop,
  input wire logic o_txt_valid,
  input wire logic [7:0] o_txt_data,
  input wire logic o_txt_eol,
  input wire logic [1:0] o_txt_cmd,
  input wire logic o_tx_echo
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_rst_n);
  wire logic rx_mb = i_rx_valid && i_rx_data <= 8'h07;
  wire logic rx_tx = i_rx_valid && o_mode == 2'h2;
  property p_sel_mb;
    o_mode == 2'h0 && rx_mb |=> o_mode == 2'h1 && o_mb_sop && o_mb_data == $past(i_rx_data);
  endproperty
  property p_sel_txt;
    o_mode == 2'h0 && i_rx_valid && i_rx_data > 8'h07 |=> o_mode == 2'h2;
  endproperty
  property p_hold; o_mode != 2'h0 |=> $stable(o_mode); endproperty
  property p_fwd; o_mode == 2'h1 && i_rx_valid |=> o_mb_valid && !o_txt_valid; endproperty
  property p_eol; rx_tx && i_rx_data == 8'h0d |=> o_txt_eol && !o_txt_valid; endproperty
  property p_cause; o_txt_eol |-> $past(i_rx_valid) && $past(i_rx_data) == 8'h0d; endproperty
  property p_fold;
    rx_tx && i_rx_data inside {[8'h41:8'h5a]} |=> o_txt_data == ($past(i_rx_data) | 8'h20);
  endproperty
  property p_echo; o_tx_echo == 1'b0; endproperty
  a_sel_mb: assert property (p_sel_mb) else $error("modbus pick");
  a_sel_txt: assert property (p_sel_txt) else $error("text pick");
  a_hold: assert property (p_hold) else $error("mode moved");
  a_fwd: assert property (p_fwd) else $error("modbus byte lost");
  a_eol: assert property (p_eol) else $error("no eol");
  a_cause: assert property (p_cause) else $error("stray eol");
  a_fold: assert property (p_fold) else $error("case");
  a_echo: assert property (p_echo) else $error("echo");
  c_eop: cover property (o_mb_eop);
  c_coil: cover property (o_txt_eol && o_txt_cmd == 2'h2);
  c_set: cover property (o_txt_eol && o_txt_cmd == 2'h1);
endmodule // hps_chk

/* verif/test_host_protocol_selector.sv */
// Bench for the selector.
// Assumes hps_host and hps_chk compiled first.
`timescale 1ns/100ps
module test_host_protocol_selector;
  logic i_mclk, i_rst_n, i_rx_valid, o_mb_valid, o_mb_sop, o_mb_eop;
  logic o_txt_valid, o_txt_eol, o_tx_echo;
  logic [7:0] i_rx_data, o_mb_data, o_txt_data;
  logic [1:0] o_mode, o_txt_cmd;
  int n_errors = 0;
  int comparisons = 0;
  localparam int GAP = 10;
  hps_host hps_host_i (.i_mclk(i_mclk), .o_valid(i_rx_valid), .o_data(i_rx_data));
  hps_selector #(.GAP_CYC(GAP)) hps_selector_i (
    .i_mclk(i_mclk),
    .i_rst_n(i_rst_n),
    .i_rx_valid(i_rx_valid),
    .i_rx_data(i_rx_data),
    .o_mode(o_mode),
    .o_mb_valid(o_mb_valid),
    .o_mb_data(o_mb_data),
    .o_mb_sop(o_mb_sop),
    .o_mb_eop(o_mb_eop),
    .o_txt_valid(o_txt_valid),
    .o_txt_data(o_txt_data),
    .o_txt_eol(o_txt_eol),
    .o_txt_cmd(o_txt_cmd),
    .o_tx_echo(o_tx_echo)
  );
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic restart;
    i_rst_n = 1'b0;
    repeat (10) @(negedge i_mclk);
    i_rst_n = 1'b1;
  endtask
  task automatic line(input string s, input logic [1:0] cmd);
    foreach (s[k]) hps_host_i.send(s[k]);
    hps_host_i.send(8'h0d);
    chk({7'h00, o_txt_eol}, 8'h01);
    chk({6'h00, o_txt_cmd}, {6'h00, cmd});
  endtask
  task automatic t_modbus;
    int n;
    restart;
    hps_host_i.send(8'h07);
    chk({6'h00, o_mode}, 8'h01);
    chk({7'h00, o_mb_sop}, 8'h01);
    chk(o_mb_data, 8'h07);
    hps_host_i.send(8'h41);
    chk({6'h00, o_mode}, 8'h01);
    chk(o_mb_data, 8'h41);
    n = 0;
    while (!o_mb_eop && n < 40) begin
      @(negedge i_mclk);
      n++;
    end
    chk({7'h00, o_mb_eop}, 8'h01);
    chk(8'(n), 8'(GAP));
    hps_host_i.send(8'h02);
    chk({7'h00, o_mb_sop}, 8'h01);
  endtask
  task automatic t_text;
    restart;
    hps_host_i.send(8'h08);
    chk({6'h00, o_mode}, 8'h02);
    chk(o_txt_data, 8'h08);
    chk({7'h00, o_txt_valid}, 8'h01);
    chk({7'h00, o_tx_echo}, 8'h00);
    line("", 2'h3);
    hps_host_i.send(8'h51);
    chk(o_txt_data, 8'h71);
    line("", 2'h3);
    line("SeT x 1", 2'h1);
    line("=PPM", 2'h0);
    line("", 2'h3);
    line("!c", 2'h2);
    hps_host_i.send(8'h03);
    chk({6'h00, o_mode}, 8'h02);
    chk({7'h00, o_mb_valid}, 8'h00);
  endtask
  task automatic conclude;
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  initial begin
    i_rst_n = 1'b0;
    t_modbus;
    t_text;
    conclude;
  end
  initial begin
    #100us;
    n_errors++;
    conclude;
  end
endmodule // test_host_protocol_selector
bind hps_selector hps_chk hps_chk_i (
  .i_mclk(i_mclk),
  .i_rst_n(i_rst_n),
  .i_rx_valid(i_rx_valid),
  .i_rx_data(i_rx_data),
  .o_mode(o_mode),
  .o_mb_valid(o_mb_valid),
  .o_mb_data(o_mb_data),
  .o_mb_sop(o_mb_sop),
  .o_mb_eop(o_mb_eop),
  .o_txt_valid(o_txt_valid),
  .o_txt_data(o_txt_data),
  .o_txt_eol(o_txt_eol),
  .o_txt_cmd(o_txt_cmd),
  .o_tx_echo(o_tx_echo)
);
